/* File: dpsc_top.sv */
// dual synthesizer serial configuration and control, top level
`timescale 1ns/100ps
`include "dpsc_params.svh"
module dpsc_top (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic serial_clock,
  input  wire logic serial_data,
  input  wire logic load_strobe,
  input  wire logic power_save_pin_if,
  input  wire logic power_save_pin_rf,
  input  wire logic reference_oscillator_input,
  input  wire logic feedback_input_if,
  input  wire logic feedback_input_rf,
  output logic      detector_out_if,
  output logic      detector_oe_if,
  output logic      detector_out_rf,
  output logic      detector_oe_rf,
  output logic      pump_current_high_if,
  output logic      pump_current_high_rf,
  output logic      power_saving_if,
  output logic      power_saving_rf,
  output logic      monitor_pin
);
  import dpsc_pkg::*;

  // every pin is slow against the 10 MHz clock, so all of them share one filter
  logic [`DPSC_IN_COUNT-1:0]  sync_one;
  logic [`DPSC_IN_COUNT-1:0]  sync_two;
  logic [`DPSC_IN_COUNT-1:0]  sync_three;
  logic [`DPSC_IN_COUNT-1:0]  level;
  logic [`DPSC_IN_COUNT-1:0]  rise;
  logic [`DPSC_WORD_BITS-1:0] shift_reg;
  logic [1:0]                 word_sel;
  logic                       load_rise;
  logic                       sclk_rise;
  logic                       active_if;
  logic                       active_rf;
  dpsc_ratio_type             ref_ratio_if;
  dpsc_ratio_type             ref_ratio_rf;
  dpsc_main_type              main_count_if;
  dpsc_main_type              main_count_rf;
  dpsc_swallow_type           swallow_count_if;
  dpsc_swallow_type           swallow_count_rf;
  logic                       modulus_if;
  logic                       modulus_rf;
  logic                       polarity_if;
  logic                       polarity_rf;
  logic                       monitor_bit_one;
  logic                       monitor_bit_two;
  logic                       monitor_source_select;
  logic                       locked_if;
  logic                       locked_rf;
  logic                       fr_if;
  logic                       fr_rf;
  logic                       fp_if;
  logic                       fp_rf;
  logic                       lock_all;
  logic                       next_monitor;

  function automatic logic sel_is(input logic [1:0] sel, input logic [1:0] code);
    sel_is = (sel == code);
  endfunction : sel_is

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync_one <= '0;
      sync_two <= '0;
      sync_three <= '0;
    end else begin
      sync_one <= {feedback_input_rf, feedback_input_if, reference_oscillator_input,
                   power_save_pin_rf, power_save_pin_if, load_strobe, serial_data,
                   serial_clock};
      sync_two <= sync_one;
      sync_three <= sync_two;
    end
  end

  // a level is accepted only once the second and third stages agree
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) level <= '0;
    else begin
      for (int i = 0; i < `DPSC_IN_COUNT; i++) begin
        if (sync_two[i] == sync_three[i]) level[i] <= sync_three[i];
      end
    end
  end

  assign rise = sync_two & sync_three & ~level;
  assign sclk_rise = rise[`DPSC_IN_SCLK];
  assign load_rise = rise[`DPSC_IN_LOAD];
  assign active_if = level[`DPSC_IN_PS_IF];
  assign active_rf = level[`DPSC_IN_PS_RF];
  assign word_sel = {shift_reg[`DPSC_SEL_FIRST], shift_reg[`DPSC_SEL_SECOND]};

  // last bit in lands at index 0, so index k-1 holds position k
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) shift_reg <= '0;
    else if (sclk_rise) shift_reg <= {shift_reg[`DPSC_WORD_BITS-2:0],
                                      level[`DPSC_IN_DATA]};
  end

  // a load strobe seen mid-word latches whatever is shifted in so far
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ref_ratio_if <= `DPSC_RST_REF;
      ref_ratio_rf <= `DPSC_RST_REF;
      pump_current_high_if <= `DPSC_RST_CS;
      pump_current_high_rf <= `DPSC_RST_CS;
      monitor_bit_one <= 1'b0;
      monitor_bit_two <= 1'b0;
    end else if (load_rise) begin
      if (sel_is(word_sel, `DPSC_SEL_IF_REF)) begin
        ref_ratio_if <= shift_reg[`DPSC_REF_MSB:`DPSC_REF_LSB];
        pump_current_high_if <= shift_reg[`DPSC_CS_BIT];
        monitor_bit_one <= shift_reg[`DPSC_MON_ONE];
        monitor_bit_two <= shift_reg[`DPSC_MON_TWO];
      end
      if (sel_is(word_sel, `DPSC_SEL_RF_REF)) begin
        ref_ratio_rf <= shift_reg[`DPSC_REF_MSB:`DPSC_REF_LSB];
        pump_current_high_rf <= shift_reg[`DPSC_CS_BIT];
        monitor_bit_one <= shift_reg[`DPSC_MON_ONE];
        monitor_bit_two <= shift_reg[`DPSC_MON_TWO];
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      main_count_if <= `DPSC_RST_MAIN;
      main_count_rf <= `DPSC_RST_MAIN;
      swallow_count_if <= `DPSC_RST_SWALLOW;
      swallow_count_rf <= `DPSC_RST_SWALLOW;
      modulus_if <= `DPSC_RST_SW;
      modulus_rf <= `DPSC_RST_SW;
      polarity_if <= `DPSC_RST_FC;
      polarity_rf <= `DPSC_RST_FC;
      monitor_source_select <= 1'b0;
    end else if (load_rise) begin
      if (sel_is(word_sel, `DPSC_SEL_IF_CNT)) begin
        main_count_if <= shift_reg[`DPSC_N_MSB:`DPSC_N_LSB];
        swallow_count_if <= shift_reg[`DPSC_A_MSB:`DPSC_A_LSB];
        modulus_if <= shift_reg[`DPSC_SW_BIT];
        polarity_if <= shift_reg[`DPSC_FC_BIT];
        monitor_source_select <= shift_reg[`DPSC_LDS_BIT];
      end
      if (sel_is(word_sel, `DPSC_SEL_RF_CNT)) begin
        main_count_rf <= shift_reg[`DPSC_N_MSB:`DPSC_N_LSB];
        swallow_count_rf <= shift_reg[`DPSC_A_MSB:`DPSC_A_LSB];
        modulus_rf <= shift_reg[`DPSC_SW_BIT];
        polarity_rf <= shift_reg[`DPSC_FC_BIT];
        monitor_source_select <= shift_reg[`DPSC_LDS_BIT];
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      power_saving_if <= 1'b1;
      power_saving_rf <= 1'b1;
    end else begin
      power_saving_if <= ~active_if;
      power_saving_rf <= ~active_rf;
    end
  end

  dpsc_section #(.IS_RF(1'b0)) section_if (
    .clock                    (clock),
    .resetn                   (resetn),
    .osc_rise                 (rise[`DPSC_IN_OSC]),
    .feed_rise                (rise[`DPSC_IN_FB_IF]),
    .active                   (active_if),
    .reference_ratio          (ref_ratio_if),
    .main_count               (main_count_if),
    .swallow_count            (swallow_count_if),
    .prescaler_modulus_select (modulus_if),
    .detector_polarity        (polarity_if),
    .reference_compare_freq   (fr_if),
    .divided_compare_freq     (fp_if),
    .detector_out             (detector_out_if),
    .detector_oe              (detector_oe_if),
    .locked                   (locked_if)
  );

  dpsc_section #(.IS_RF(1'b1)) section_rf (
    .clock                    (clock),
    .resetn                   (resetn),
    .osc_rise                 (rise[`DPSC_IN_OSC]),
    .feed_rise                (rise[`DPSC_IN_FB_RF]),
    .active                   (active_rf),
    .reference_ratio          (ref_ratio_rf),
    .main_count               (main_count_rf),
    .swallow_count            (swallow_count_rf),
    .prescaler_modulus_select (modulus_rf),
    .detector_polarity        (polarity_rf),
    .reference_compare_freq   (fr_rf),
    .divided_compare_freq     (fp_rf),
    .detector_out             (detector_out_rf),
    .detector_oe              (detector_oe_rf),
    .locked                   (locked_rf)
  );

  assign lock_all = (locked_if | ~active_if) & (locked_rf | ~active_rf);

  // the unlisted lock-source code 01 reads low rather than guessing a source
  always_comb begin
    case ({monitor_source_select, monitor_bit_one, monitor_bit_two})
      3'h0, 3'h2, 3'h3: next_monitor = lock_all;
      3'h4: next_monitor = fr_if;
      3'h6: next_monitor = fr_rf;
      3'h5: next_monitor = fp_if;
      3'h7: next_monitor = fp_rf;
      default: next_monitor = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) monitor_pin <= 1'b0;
    else monitor_pin <= next_monitor;
  end

  sequence sclk_edge_s;
    sclk_rise;
  endsequence

  sequence load_word_s(logic [1:0] code);
    load_rise && word_sel == code;
  endsequence

  shift_in_a: assert property (@(posedge clock) disable iff (!resetn)
    sclk_edge_s |=> shift_reg == {$past(shift_reg[`DPSC_WORD_BITS-2:0]),
                                  $past(level[`DPSC_IN_DATA])})
    else $error("shift register did not take the data bit");
  shift_hold_a: assert property (@(posedge clock) disable iff (!resetn)
    !sclk_rise |=> $stable(shift_reg)) else $error("shift register moved without edge");
  if_ref_load_a: assert property (@(posedge clock) disable iff (!resetn)
    load_word_s(`DPSC_SEL_IF_REF) |=>
      ref_ratio_if == $past(shift_reg[`DPSC_REF_MSB:`DPSC_REF_LSB]) && $stable(ref_ratio_rf))
    else $error("IF reference latch not loaded");
  rf_cnt_load_a: assert property (@(posedge clock) disable iff (!resetn)
    load_word_s(`DPSC_SEL_RF_CNT) |=>
      main_count_rf == $past(shift_reg[`DPSC_N_MSB:`DPSC_N_LSB]) &&
      swallow_count_rf == $past(shift_reg[`DPSC_A_MSB:`DPSC_A_LSB]) &&
      $stable(main_count_if))
    else $error("RF counter latch not loaded");
  pump_select_a: assert property (@(posedge clock) disable iff (!resetn)
    load_word_s(`DPSC_SEL_RF_REF) |=> pump_current_high_rf == $past(shift_reg[`DPSC_CS_BIT]))
    else $error("pump current not taken from word");
  if_cnt_load_a: assert property (@(posedge clock) disable iff (!resetn)
    load_word_s(`DPSC_SEL_IF_CNT) |=>
      modulus_if == $past(shift_reg[`DPSC_SW_BIT]) &&
      polarity_if == $past(shift_reg[`DPSC_FC_BIT]) &&
      monitor_source_select == $past(shift_reg[`DPSC_LDS_BIT]))
    else $error("IF counter control bits not loaded");
  monitor_lock_a: assert property (@(posedge clock) disable iff (!resetn)
    !monitor_source_select && !monitor_bit_two |=> monitor_pin == $past(lock_all))
    else $error("monitor pin not showing lock");
  saving_lock_a: assert property (@(posedge clock) disable iff (!resetn)
    !active_if && !active_rf && !monitor_source_select && !monitor_bit_two |=> monitor_pin)
    else $error("lock indicator low with both sections saving");
  ps_enter_a: assert property (@(posedge clock) disable iff (!resetn)
    $fell(sync_three[`DPSC_IN_PS_IF]) && !sync_two[`DPSC_IN_PS_IF] |=> ##1 power_saving_if)
    else $error("power save not entered");
  if_cnt_count_a: assert property (@(posedge clock) disable iff (!resetn)
    load_word_s(`DPSC_SEL_IF_CNT) |=>
      swallow_count_if == $past(shift_reg[`DPSC_A_MSB:`DPSC_A_LSB]) &&
      main_count_if == $past(shift_reg[`DPSC_N_MSB:`DPSC_N_LSB]))
    else $error("IF counts not loaded");
  rf_ref_load_a: assert property (@(posedge clock) disable iff (!resetn)
    load_word_s(`DPSC_SEL_RF_REF) |=>
      ref_ratio_rf == $past(shift_reg[`DPSC_REF_MSB:`DPSC_REF_LSB]) && $stable(ref_ratio_if))
    else $error("RF reference latch not loaded");
  rf_cnt_ctrl_a: assert property (@(posedge clock) disable iff (!resetn)
    load_word_s(`DPSC_SEL_RF_CNT) |=>
      modulus_rf == $past(shift_reg[`DPSC_SW_BIT]) &&
      polarity_rf == $past(shift_reg[`DPSC_FC_BIT]))
    else $error("RF counter control bits not loaded");
  latch_hold_a: assert property (@(posedge clock) disable iff (!resetn)
    !load_rise |=> $stable(ref_ratio_if) && $stable(main_count_rf) && $stable(modulus_if))
    else $error("latch changed without load strobe");
  monitor_fout_a: assert property (@(posedge clock) disable iff (!resetn)
    monitor_source_select && !monitor_bit_one && monitor_bit_two |=>
      monitor_pin == $past(fp_if))
    else $error("monitor pin not showing divided IF pulse");
  lock_low_a: assert property (@(posedge clock) disable iff (!resetn)
    active_if && !locked_if && !monitor_source_select && !monitor_bit_two |=> !monitor_pin)
    else $error("lock indicator high with IF unlocked");
endmodule : dpsc_top

/* File: dpsc_params.svh */
// constants of the dual synthesizer configuration block
`ifndef DPSC_PARAMS_SVH
`define DPSC_PARAMS_SVH
`define DPSC_WORD_BITS      23
`define DPSC_SEL_FIRST      0
`define DPSC_SEL_SECOND     1
`define DPSC_MON_ONE        2
`define DPSC_MON_TWO        3
`define DPSC_REF_LSB        4
`define DPSC_REF_MSB        17
`define DPSC_CS_BIT         18
`define DPSC_LDS_BIT        2
`define DPSC_SW_BIT         3
`define DPSC_FC_BIT         4
`define DPSC_A_LSB          5
`define DPSC_A_MSB          11
`define DPSC_N_LSB          12
`define DPSC_N_MSB          22
`define DPSC_SEL_IF_REF     2'h0
`define DPSC_SEL_IF_CNT     2'h1
`define DPSC_SEL_RF_REF     2'h2
`define DPSC_SEL_RF_CNT     2'h3
`define DPSC_RST_REF        14'h0003
`define DPSC_RST_MAIN       11'h003
`define DPSC_RST_SWALLOW    7'h00
`define DPSC_RST_SW         1'h1
`define DPSC_RST_FC         1'h1
`define DPSC_RST_CS         1'h0
`define DPSC_IF_P_HIGH      8'h08
`define DPSC_IF_P_LOW       8'h10
`define DPSC_RF_P_HIGH      8'h40
`define DPSC_RF_P_LOW       8'h80
`define DPSC_UNLOCK_CYCLES  4'h2
`define DPSC_LOCK_CYCLES    4'h4
`define DPSC_LOCK_RUN       2'h2
`define DPSC_ERR_MAX        4'hF
`define DPSC_IN_COUNT       8
`define DPSC_IN_SCLK        0
`define DPSC_IN_DATA        1
`define DPSC_IN_LOAD        2
`define DPSC_IN_PS_IF       3
`define DPSC_IN_PS_RF       4
`define DPSC_IN_OSC         5
`define DPSC_IN_FB_IF       6
`define DPSC_IN_FB_RF       7
`endif

/* File: dpsc_pkg.sv */
// types of the dual synthesizer configuration block
package dpsc_pkg;
  typedef logic [13:0] dpsc_ratio_type;
  typedef logic [10:0] dpsc_main_type;
  typedef logic [6:0]  dpsc_swallow_type;
  typedef enum logic {lock_lost, lock_held} dpsc_lock_type;
endpackage : dpsc_pkg

/* File: dpsc_section.sv */
// one synthesizer section: dividers, phase detector, lock detect
`timescale 1ns/100ps
`include "dpsc_params.svh"
module dpsc_section #(
  parameter bit IS_RF = 1'b0
) (
  input  wire logic                       clock,
  input  wire logic                       resetn,
  input  wire logic                       osc_rise,
  input  wire logic                       feed_rise,
  input  wire logic                       active,
  input  wire dpsc_pkg::dpsc_ratio_type   reference_ratio,
  input  wire dpsc_pkg::dpsc_main_type    main_count,
  input  wire dpsc_pkg::dpsc_swallow_type swallow_count,
  input  wire logic                       prescaler_modulus_select,
  input  wire logic                       detector_polarity,
  output logic                            reference_compare_freq,
  output logic                            divided_compare_freq,
  output logic                            detector_out,
  output logic                            detector_oe,
  output logic                            locked
);
  import dpsc_pkg::*;

  function automatic logic [7:0] prescale_base(input logic high);
    if (IS_RF) prescale_base = high ? `DPSC_RF_P_HIGH : `DPSC_RF_P_LOW;
    else       prescale_base = high ? `DPSC_IF_P_HIGH : `DPSC_IF_P_LOW;
  endfunction : prescale_base

  logic             active_d;
  logic [13:0]      ref_cnt;
  logic [7:0]       pre_cnt;
  logic [10:0]      main_cnt;
  logic [6:0]       swallow_left;
  logic             up;
  logic             dn;
  logic [3:0]       err_cnt;
  logic [1:0]       good_cnt;
  dpsc_lock_type    lock_state;
  logic             wake;
  logic             hold;
  logic [7:0]       pre_limit;
  logic             pre_wrap;

  // restarting both dividers together on wake keeps the first error small
  assign wake = active & ~active_d;
  assign hold = ~active | wake;
  assign pre_limit = (swallow_left != 7'h00) ? prescale_base(prescaler_modulus_select)
                   : prescale_base(prescaler_modulus_select) - 8'h01;
  assign pre_wrap = feed_rise & (pre_cnt >= pre_limit);
  assign locked = (lock_state == lock_held);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) active_d <= 1'b0;
    else active_d <= active;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ref_cnt <= 14'h0000;
      reference_compare_freq <= 1'b0;
    end else if (hold) begin
      ref_cnt <= 14'h0000;
      reference_compare_freq <= 1'b0;
    end else if (osc_rise && ref_cnt >= reference_ratio - 14'h0001) begin
      ref_cnt <= 14'h0000;
      reference_compare_freq <= 1'b1;
    end else begin
      ref_cnt <= ref_cnt + {13'h0000, osc_rise};
      reference_compare_freq <= 1'b0;
    end
  end

  // first swallow_count prescaler cycles divide by base plus one
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) pre_cnt <= 8'h00;
    else if (hold || pre_wrap) pre_cnt <= 8'h00;
    else if (feed_rise) pre_cnt <= pre_cnt + 8'h01;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      main_cnt <= 11'h000;
      swallow_left <= 7'h00;
      divided_compare_freq <= 1'b0;
    end else if (hold) begin
      main_cnt <= 11'h000;
      swallow_left <= swallow_count;
      divided_compare_freq <= 1'b0;
    end else if (pre_wrap && main_cnt >= main_count - 11'h001) begin
      main_cnt <= 11'h000;
      swallow_left <= swallow_count;
      divided_compare_freq <= 1'b1;
    end else begin
      if (pre_wrap) begin
        main_cnt <= main_cnt + 11'h001;
        swallow_left <= swallow_left - {6'h00, swallow_left != 7'h00};
      end
      divided_compare_freq <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      up <= 1'b0;
      dn <= 1'b0;
    end else if (hold) begin
      up <= 1'b0;
      dn <= 1'b0;
    end else begin
      up <= (up | reference_compare_freq) & ~(dn | divided_compare_freq);
      dn <= (dn | divided_compare_freq) & ~(up | reference_compare_freq);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      detector_out <= 1'b0;
      detector_oe <= 1'b0;
    end else begin
      detector_oe <= active & ~wake & (up ^ dn);
      detector_out <= detector_polarity ? up : ~up;
    end
  end

  // error width in oscillator periods, judged at each reference pulse
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) err_cnt <= 4'h0;
    else if (hold || reference_compare_freq) err_cnt <= 4'h0;
    else if (osc_rise && (up | dn) && err_cnt != `DPSC_ERR_MAX) err_cnt <= err_cnt + 4'h1;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lock_state <= lock_lost;
      good_cnt <= 2'h0;
    end else if (hold) begin
      lock_state <= lock_lost;
      good_cnt <= 2'h0;
    end else if (reference_compare_freq) begin
      case (lock_state)
        lock_lost: begin
          if (err_cnt <= `DPSC_LOCK_CYCLES) begin
            good_cnt <= good_cnt + 2'h1;
            if (good_cnt == `DPSC_LOCK_RUN) lock_state <= lock_held;
          end else good_cnt <= 2'h0;
        end
        lock_held: begin
          good_cnt <= 2'h0;
          if (err_cnt >= `DPSC_UNLOCK_CYCLES) lock_state <= lock_lost;
        end
        default: lock_state <= lock_lost;
      endcase
    end
  end

  idle_hiz_a: assert property (@(posedge clock) disable iff (!resetn)
    !active |=> !detector_oe) else $error("detector driven in power save");
  pol_drive_a: assert property (@(posedge clock) disable iff (!resetn)
    detector_oe |-> detector_out == ($past(detector_polarity) ~^ $past(up)))
    else $error("detector level does not follow polarity");
  wake_align_a: assert property (@(posedge clock) disable iff (!resetn)
    wake |=> ref_cnt == 14'h0000 && !up && !dn && !detector_oe)
    else $error("dividers not restarted on wake");
  lock_gain_a: assert property (@(posedge clock) disable iff (!resetn)
    $rose(locked) |-> $past(good_cnt) == `DPSC_LOCK_RUN && $past(err_cnt) <= `DPSC_LOCK_CYCLES)
    else $error("lock flagged without three good cycles");
endmodule : dpsc_section

/* File: dpsc_host.sv */
// host model driving the three-wire configuration link
`timescale 1ns/100ps
module dpsc_host (
  output logic serial_clock,
  output logic serial_data,
  output logic load_strobe
);
  initial begin
    serial_clock = 1'b0;
    serial_data  = 1'b0;
    load_strobe  = 1'b0;
  end
  // link clock idles low between frames; 800 ns bit period
  task automatic send(input logic [22:0] w);
    for (int i = 22; i >= 0; i--) begin
      serial_data = w[i];
      #400 serial_clock = 1'b1;
      #400 serial_clock = 1'b0;
    end
    #400 load_strobe = 1'b1;
    #400 load_strobe = 1'b0;
    // no pull on the data line, so a released line shows the inverse
    serial_data = ~w[0];
  endtask : send
endmodule : dpsc_host

/* File: dual_pll_serial_config_tb.sv */
// self-checking bench of the dual synthesizer configuration block
`timescale 1ns/100ps
module dual_pll_serial_config_tb;
  logic clock  = 1'b0;
  logic resetn = 1'b0;
  logic ps_if  = 1'b0;
  logic ps_rf  = 1'b0;
  logic osc    = 1'b0;
  logic sclk, sdata, load, do_if, oe_if, do_rf, oe_rf, cs_if, cs_rf, save_if, save_rf, mon;
  int   bad_count   = 0;
  int   checks_done = 0;
  int   cycles      = 0;
  always #50 clock = ~clock;
  always #500 osc = ~osc;
  dpsc_host host_u (.serial_clock(sclk), .serial_data(sdata), .load_strobe(load));
  dpsc_top dut_u (.clock(clock), .resetn(resetn), .serial_clock(sclk), .serial_data(sdata),
    .load_strobe(load), .power_save_pin_if(ps_if), .power_save_pin_rf(ps_rf),
    .reference_oscillator_input(osc), .feedback_input_if(osc), .feedback_input_rf(osc),
    .detector_out_if(do_if), .detector_oe_if(oe_if), .detector_out_rf(do_rf),
    .detector_oe_rf(oe_rf), .pump_current_high_if(cs_if), .pump_current_high_rf(cs_rf),
    .power_saving_if(save_if), .power_saving_rf(save_rf), .monitor_pin(mon));
  task automatic check(input string name, input logic seen, input logic exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", name, exp, seen);
    end
  endtask : check
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // ratio defaults to 3, the reset value of the reference latch
  function automatic logic [22:0] ref_word(input logic [1:0] sel, input logic t1, t2, cs,
                                           input logic [13:0] r = 14'h0003);
    return {4'hF, cs, r, t2, t1, sel[0], sel[1]};
  endfunction : ref_word
  // main 69, swallow 2: swallow below main, and main bit 6 sits where pump select would
  function automatic logic [22:0] cnt_word(input logic [1:0] sel, input logic src,
                                           input logic fc = 1'b1, sw = 1'b1,
                                           input logic [10:0] n = 11'h045,
                                           input logic [6:0] a = 7'h02);
    return {n, a, fc, sw, src, sel[0], sel[1]};
  endfunction : cnt_word
  task automatic load_word(input logic [22:0] w);
    host_u.send(w);
    tick(10);
  endtask : load_word
  task automatic t_reset;
    check("saving_if", save_if, 1'b1);
    check("saving_rf", save_rf, 1'b1);
    check("oe_if", oe_if, 1'b0);
    check("oe_rf", oe_rf, 1'b0);
    check("pump_if", cs_if, 1'b0);
    check("lock_ind", mon, 1'b1);
    check("do_if", do_if, 1'b0);
    check("do_rf", do_rf, 1'b0);
  endtask : t_reset
  task automatic pump(input logic [1:0] sel, input logic cs, e_if, e_rf);
    load_word(ref_word(sel, 1'b0, 1'b0, cs));
    check("pump_if", cs_if, e_if);
    check("pump_rf", cs_rf, e_rf);
  endtask : pump
  task automatic t_pump;
    pump(2'h0, 1'b1, 1'b1, 1'b0);
    pump(2'h2, 1'b1, 1'b1, 1'b1);
    pump(2'h0, 1'b0, 1'b0, 1'b1);
    // counter words must leave both reference latches alone
    load_word(cnt_word(2'h1, 1'b0));
    load_word(cnt_word(2'h3, 1'b0));
    check("pump_if", cs_if, 1'b0);
    check("pump_rf", cs_rf, 1'b1);
  endtask : t_pump
  task automatic mon_case(input logic t1, t2, e);
    load_word(ref_word(2'h0, t1, t2, 1'b0));
    check("monitor", mon, e);
  endtask : mon_case
  task automatic t_monitor;
    mon_case(1'b0, 1'b1, 1'b0);
    mon_case(1'b1, 1'b0, 1'b1);
    mon_case(1'b1, 1'b1, 1'b1);
    mon_case(1'b0, 1'b0, 1'b1);
  endtask : t_monitor
  task automatic t_wake;
    int n;
    ps_if = 1'b1;
    tick(8);
    check("saving_if", save_if, 1'b0);
    check("lock_ind", mon, 1'b0);
    load_word(cnt_word(2'h1, 1'b1));
    n = 0;
    // ratio 3 on a 1 us oscillator: one pulse every 30 cycles
    repeat (300) begin
      tick(1);
      n += mon;
    end
    check("ref_pulses", n >= 9 && n <= 11, 1'b1);
    // feedback is far slower than reference here, so the detector pushes up
    check("oe_if", oe_if, 1'b1);
    check("do_if", do_if, 1'b1);
    load_word(cnt_word(2'h1, 1'b1, 1'b0));
    check("oe_if", oe_if, 1'b1);
    check("do_if", do_if, 1'b0);
    ps_if = 1'b0;
    tick(8);
    check("saving_if", save_if, 1'b1);
    n = 0;
    repeat (50) begin
      tick(1);
      n += oe_if;
    end
    check("oe_if_off", n == 0, 1'b1);
  endtask : t_wake
  // reference 48 and feedback 16 x 3 divide alike: no drive, lock after three cycles
  task automatic t_lock;
    int n;
    load_word(ref_word(2'h0, 1'b0, 1'b0, 1'b0, 14'h0030));
    load_word(cnt_word(2'h1, 1'b0, 1'b1, 1'b0, 11'h003, 7'h00));
    ps_if = 1'b1;
    tick(1700);
    check("lock_ind", mon, 1'b1);
    check("oe_if", oe_if, 1'b0);
    load_word(ref_word(2'h0, 1'b0, 1'b1, 1'b0, 14'h0030));
    load_word(cnt_word(2'h1, 1'b1, 1'b1, 1'b0, 11'h003, 7'h00));
    n = 0;
    // one divided pulse every 480 cycles
    repeat (960) begin
      tick(1);
      n += mon;
    end
    check("fp_pulses", n == 2, 1'b1);
  endtask : t_lock
  initial begin
    tick(8);
    resetn = 1'b1;
    tick(8);
    t_reset();
    t_pump();
    t_monitor();
    t_wake();
    t_lock();
    results();
  end
endmodule : dual_pll_serial_config_tb
